// File: sim/mbc_controller_tb.sv
// self-checking bench for the memory self-test controller
`timescale 1ns/10ps
module mbc_controller_tb import mbc_pkg::*;
;
	logic clock, reset, wbCycI, wbStbI, wbWeI, wbAckO, potStartPin, concurrentTestSelect;
	logic potDone, potPass, funcClkIn, testMemClk, memClk, memWrite, failPulseFlag;
	logic testBusy, bypassClkIn, allOn, bypassEn;
	logic [7:0] wbAdrI, memAddr;
	logic [7:0] addrLog [4];
	logic [31:0] wbDatI, wbDatO, rd, memWdata, bypassData, firstData, funcWdata;
	logic [1:0] memEnable, passFlags, faultMask;
	logic [63:0] memRdata;
	logic [3:0] romElemAddr;
	logic [4:0] romElemData;
	logic [4:0] romTable [16];
	int miscompares, comparisons, cycles, steps, writes, fails;
	assign romElemData = romTable[romElemAddr];
	// ==========================================
	// design and memories
	mbc_controller #(.NMEM(2)) mbc_controller_i (.clock(clock), .reset(reset),
		.wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(4'hF),
		.wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO), .potStartPin(potStartPin),
		.concurrentTestSelect(concurrentTestSelect), .potDone(potDone), .potPass(potPass),
		.funcClkIn(funcClkIn), .testMemClk(testMemClk), .memClk(memClk),
		.memEnable(memEnable), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
		.memRdata(memRdata), .romElemAddr(romElemAddr), .romElemData(romElemData),
		.bypassClkIn(bypassClkIn), .bypassEn(bypassEn), .funcWdata(funcWdata),
		.bypassData(bypassData), .passFlags(passFlags), .failPulseFlag(failPulseFlag),
		.testBusy(testBusy));
	mbc_mem_model mbc_mem_model_i (.memClk(memClk), .memEnable(memEnable),
		.memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .faultMask(faultMask),
		.memRdata(memRdata));
	// ==========================================
	// clocks
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		funcClkIn = 1'b0;
		bypassClkIn = 1'b0;
		forever #20 {funcClkIn, bypassClkIn} = ~{funcClkIn, bypassClkIn};
	end
	// step monitor and run-time limit
	always @(posedge clock) begin
		cycles++;
		if (memEnable !== 2'b00 && !reset) begin
			if (steps < 4) addrLog[steps] = memAddr;
			if (memWrite === 1'b1 && writes == 0) firstData = memWdata;
			writes += int'(memWrite === 1'b1);
			steps++;
			allOn |= (memEnable === 2'b11);
		end
		fails += int'(failPulseFlag === 1'b0);
		if (cycles == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end
	// ==========================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wbCycI <= 1'b1;
		wbStbI <= 1'b1;
		wbWeI <= we;
		wbAdrI <= a;
		wbDatI <= d;
		@(posedge clock);
		while (wbAckO !== 1'b1) @(posedge clock);
		rd = wbDatO;
		wbCycI <= 1'b0;
		wbStbI <= 1'b0;
		@(posedge clock);
	endtask
	task automatic run(input logic [31:0] ctrl);
		steps = 0;
		writes = 0;
		fails = 0;
		allOn = 1'b0;
		wb(1'b1, ADDR_CTRL, ctrl);
		do wb(1'b0, ADDR_STATUS, 32'h0000_0000); while (rd[STAT_DONE] !== 1'b1);
	endtask
	task automatic report_and_stop;
		if (miscompares == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic resetCase;
		wb(1'b0, ADDR_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0600, "control reset value");
		wb(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk(rd, 32'h0003_0000, "status reset value");
		wb(1'b1, 8'h20, 32'hFFFF_FFFF);
		wb(1'b0, 8'h20, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "unmapped read");
		wb(1'b0, ADDR_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0600, "unmapped write leaked");
		chk(failPulseFlag, 1'b1, "idle go flag");
	endtask
	task automatic clockCase;
		wb(1'b1, ADDR_CTRL, 32'h0000_0780);
		repeat (3) begin
			@(negedge funcClkIn);
			#1 chk(testMemClk, funcClkIn, "hookup clock low");
			@(posedge funcClkIn);
			#1 chk(testMemClk, funcClkIn, "hookup clock high");
			chk(memClk, funcClkIn, "idle memory clock");
		end
		@(posedge clock);
		wb(1'b1, ADDR_CTRL, 32'h0000_0680);
		#1 chk(testMemClk, clock, "own test clock");
		chk(bypassData, memRdata[31:0], "bypass off data");
		@(posedge clock);
		funcWdata <= 32'h0000_1000;
		bypassEn <= 1'b1;
		repeat (2) @(posedge bypassClkIn);
		#1 chk(bypassData, 32'h0000_F000, "shared bypass group");
		@(posedge clock);
		bypassEn <= 1'b0;
	endtask
	task automatic progCase(input logic [31:0] alg, input int st, input int wr,
		input logic [7:0] a0, input logic [7:0] a1, input logic [31:0] d0, input logic [1:0] fl);
		wb(1'b1, ADDR_ALG_LO, alg);
		run(32'h0000_0647);
		chk(steps, st, "step count");
		chk(writes, wr, "write count");
		chk(addrLog[0], a0, "first address");
		chk(addrLog[1], a1, "second address");
		chk(firstData, d0, "write background");
		chk(passFlags, fl, "pass flags");
		chk(allOn, 1'b1, "concurrent start");
	endtask
	task automatic marchCase(input logic [1:0] fm, input logic [1:0] fl);
		faultMask <= fm;
		concurrentTestSelect <= 1'b0;
		repeat (4) @(posedge clock);
		run(32'h0000_0645);
		chk(steps, 112, "march step count");
		chk(writes, 40, "march write count");
		chk(allOn, 1'b0, "sequential test");
		chk(passFlags, fl, "per-memory flags");
		chk(fails > 0, fm != 2'b00, "go flag pulse");
		wb(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk(rd[17:16], fl, "status flags");
		faultMask <= 2'b00;
		concurrentTestSelect <= 1'b1;
		repeat (4) @(posedge clock);
	endtask
	task automatic potCase(input logic [2:0] mode, input int st);
		steps = 0;
		wb(1'b1, ADDR_CTRL, 32'h0000_0644 | (32'(mode) << 3));
		potStartPin <= 1'b1;
		@(posedge clock);
		while (testBusy !== 1'b1) @(posedge clock);
		@(negedge clock);
		#1 chk(memClk, clock, "test memory clock");
		while (potDone !== 1'b1) @(posedge clock);
		repeat (2) @(posedge clock);
		chk(steps, st, "power-on steps");
		chk(potPass, 1'b1, "power-on pass");
		potStartPin <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	// ==========================================
	// main sequence
	initial begin
		reset = 1'b1;
		{wbCycI, wbStbI, wbWeI, potStartPin, bypassEn} = 5'h00;
		concurrentTestSelect = 1'b1;
		wbAdrI = 8'h00;
		{wbDatI, funcWdata} = 64'h0000_0000_0000_0000;
		faultMask = 2'b00;
		{miscompares, comparisons, cycles, steps, writes, fails} = '0;
		for (int i = 0; i < 16; i++) romTable[i] = 5'h00;
		romTable[0] = 5'h04;
		romTable[1] = 5'h03;
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		resetCase();
		clockCase();
		progCase(32'h0000_0004, 4, 4, 8'h00, 8'h03, 32'h0000_0000, 2'b11);
		progCase(32'h0000_015C, 8, 4, 8'hFF, 8'hFC, 32'hFFFF_FFFF, 2'b11);
		progCase(32'h0000_0024, 12, 8, 8'h00, 8'h03, 32'h0000_0000, 2'b11);
		progCase(32'h0000_0064, 16, 8, 8'h00, 8'h03, 32'h0000_0000, 2'b11);
		progCase(32'h0000_0144, 8, 4, 8'h00, 8'h03, 32'h0000_0000, 2'b00);
		progCase(32'h0000_1004, 4, 4, 8'h00, 8'h03, 32'h0000_0000, 2'b11);
		progCase(32'h0000_0044, 8, 4, 8'h00, 8'h03, 32'h0000_0000, 2'b11);
		marchCase(2'b00, 2'b11);
		marchCase(2'b10, 2'b01);
		potCase(POT_BASIC, 56);
		potCase(POT_HARDWIRED, 56);
		potCase(POT_ROM, 16);
		potCase(POT_RAM, 8);
		report_and_stop();
	end
endmodule

// File: sim/mbc_mem_model.sv
// behavioural memories under test, one read cycle of latency
`timescale 1ns/10ps
module mbc_mem_model #(
	parameter int NMEM = 2,
	parameter int DW = 32,
	parameter int ADDR_W = 8
) (
	input wire logic memClk, // memory clock
	input wire logic [NMEM-1:0] memEnable, // enables
	input wire logic memWrite, // write strobe
	input wire logic [ADDR_W-1:0] memAddr, // address
	input wire logic [DW-1:0] memWdata, // write data
	input wire logic [NMEM-1:0] faultMask, // flip bit 0 on reads
	output logic [NMEM*DW-1:0] memRdata // read data
);
	logic [DW-1:0] store [NMEM][2**ADDR_W];
	// ==========================================
	// clear contents at time zero
	initial begin
		memRdata = '0;
		for (int m = 0; m < NMEM; m++) begin
			for (int a = 0; a < 2**ADDR_W; a++) begin
				store[m][a] = '0;
			end
		end
	end
	// clocked by the muxed memory clock; idle outputs toggle
	always @(posedge memClk) begin
		for (int m = 0; m < NMEM; m++) begin
			if (memEnable[m] && memWrite) begin
				store[m][memAddr] <= memWdata;
			end else if (memEnable[m]) begin
				memRdata[m*DW +: DW] <= store[m][memAddr] ^ DW'(faultMask[m]);
			end else begin
				memRdata[m*DW +: DW] <= ~memRdata[m*DW +: DW];
			end
		end
	end
endmodule

// File: sim/mbc_properties.sv
// concurrent checks on the ports of the memory self-test controller
`timescale 1ns/10ps
module mbc_properties import mbc_pkg::*; #(
	parameter int NMEM = 2,
	parameter int DW = 32
) (
	input wire logic clock, // controller clock
	input wire logic reset, // synchronous reset
	input wire logic wbCycI, // bus cycle
	input wire logic wbStbI, // bus strobe
	input wire logic wbAckO, // bus acknowledge
	input wire logic potDone, // power-on finished
	input wire logic potPass, // power-on result
	input wire logic [NMEM-1:0] memEnable, // memory enables
	input wire logic memWrite, // write strobe
	input wire logic [DW-1:0] memWdata, // write data
	input wire logic [NMEM-1:0] passFlags, // pass flags
	input wire logic failPulseFlag, // failure pulse
	input wire logic testBusy // test running
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// ==========================================
	// bus handshake
	sequence reqTaken;
		wbCycI && wbStbI && !wbAckO;
	endsequence
	sequence ackOnce;
		wbAckO ##1 !wbAckO;
	endsequence
	bus_ack_a: assert property (reqTaken |=> ackOnce) else $error("ack not one cycle");
	ack_cause_a: assert property (wbAckO |-> $past(wbCycI && wbStbI)) else $error("stray ack");
	// ==========================================
	// memory side and result flags
	fail_pulse_a: assert property ($fell(failPulseFlag) |=> failPulseFlag)
		else $error("fail pulse too long");
	flag_hold_a: assert property (testBusy && $past(testBusy) |->
		(passFlags & ~$past(passFlags)) == '0) else $error("pass flag rose in test");
	write_enable_a: assert property (memWrite |-> memEnable != '0)
		else $error("write without enable");
	enable_busy_a: assert property (memEnable != '0 |-> testBusy || $past(testBusy))
		else $error("enable outside test");
	enable_shape_a: assert property (memEnable != '0 |-> $onehot(memEnable) || &memEnable)
		else $error("odd enable pattern");
	write_data_a: assert property (memWrite |-> memWdata == '0 || memWdata == '1)
		else $error("write data not background");
	pot_pass_a: assert property (potPass |-> potDone && &passFlags)
		else $error("pass without done");
endmodule
bind mbc_controller mbc_properties #(.NMEM(NMEM), .DW(DW)) mbc_properties_i (.clock(clock),
	.reset(reset), .wbCycI(wbCycI), .wbStbI(wbStbI), .wbAckO(wbAckO), .potDone(potDone),
	.potPass(potPass), .memEnable(memEnable), .memWrite(memWrite), .memWdata(memWdata),
	.passFlags(passFlags), .failPulseFlag(failPulseFlag), .testBusy(testBusy));

// File: verilog/mbc_controller.sv
// memory self-test controller with wishbone register slave
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module mbc_controller import mbc_pkg::*; #(
	parameter int NMEM = 2,
	parameter int DW = 32,
	parameter int ADDR_W = 8,
	parameter int COL_W = 2,
	parameter int BYP_SHARE = 4,
	parameter bit BYPASS_CLK = 1'b1,
	parameter bit PARALLEL_ON = 1'b1,
	parameter logic [NMEM-1:0] ROM_MASK = '0,
	parameter logic [DW-1:0] ROM_SIGNATURE = '0
) (
	input wire logic clock, // controller and test memory clock
	input wire logic reset, // synchronous, active high
	input wire logic wbCycI, // wishbone cycle
	input wire logic wbStbI, // wishbone strobe
	input wire logic wbWeI, // wishbone write
	input wire logic [7:0] wbAdrI, // wishbone byte address
	input wire logic [3:0] wbSelI, // wishbone byte lanes
	input wire logic [31:0] wbDatI, // wishbone write data
	output logic [31:0] wbDatO, // wishbone read data
	output logic wbAckO, // wishbone acknowledge
	input wire logic potStartPin, // power-on start level
	input wire logic concurrentTestSelect, // external parallel select
	output logic potDone, // power-on test finished
	output logic potPass, // power-on test result
	input wire logic funcClkIn, // memory functional clock
	output logic testMemClk, // test memory clock source
	output logic memClk, // clock to the memories
	output logic [NMEM-1:0] memEnable, // per-memory enable
	output logic memWrite, // shared write strobe
	output logic [ADDR_W-1:0] memAddr, // shared address
	output logic [DW-1:0] memWdata, // shared write data
	input wire logic [NMEM*DW-1:0] memRdata, // read data, one word per memory
	output logic [3:0] romElemAddr, // command ROM element index
	input wire logic [ELEM_W-1:0] romElemData, // command ROM element
	input wire logic bypassClkIn, // dedicated bypass clock
	input wire logic bypassEn, // bypass mode
	input wire logic [DW-1:0] funcWdata, // functional memory inputs
	output logic [DW-1:0] bypassData, // memory output or bypass value
	output logic [NMEM-1:0] passFlags, // per-memory pass flags
	output logic failPulseFlag, // low one cycle per failure seen while high
	output logic testBusy // test running
);
	localparam int NBYP = (DW + BYP_SHARE - 1) / BYP_SHARE;
	localparam logic [ADDR_W-1:0] COL_MASK = ADDR_W'((1 << COL_W) - 1);
	localparam logic [ADDR_W-1:0] RED_LAST = (COL_W == 0) ? ADDR_W'(1) : ADDR_W'(3);

	// ==========================================
	// pin synchronisers
	logic [1:0] pinIn;
	logic [1:0] pinS1_q;
	logic [1:0] pinS2_q;
	logic [1:0] pinS3_q;
	logic [1:0] pinLvl_q;
	logic startLvlOld_q;
	assign pinIn = {concurrentTestSelect, potStartPin};
	// three stages; a change counts once the last two agree
	for (genvar p = 0; p < 2; p++) begin: gSync
		always_ff @(posedge clock) begin
			pinS1_q[p] <= pinIn[p];
			pinS2_q[p] <= pinS1_q[p];
			pinS3_q[p] <= pinS2_q[p];
			if (reset) begin
				pinLvl_q[p] <= 1'b0;
			end else if (pinS2_q[p] == pinS3_q[p]) begin
				pinLvl_q[p] <= pinS3_q[p];
			end
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			startLvlOld_q <= 1'b0;
		end else begin
			startLvlOld_q <= pinLvl_q[0];
		end
	end

	// ==========================================
	// register bus
	logic ack_q;
	logic [31:0] rdat_q;
	logic [CTRL_W-1:0] ctrl_q;
	logic [31:0] algLo_q;
	logic [ALG_W-33:0] algHi_q;
	logic wbTake;
	logic wbWrite;
	logic selCtrl;
	logic selStat;
	logic selLo;
	logic selHi;
	logic selSig;
	logic [31:0] rdMux;
	logic [31:0] statWord;
	logic [31:0] ctrlNew;
	logic [31:0] loNew;
	logic [31:0] hiNew;
	logic busStart;

	function automatic logic [31:0] laneMerge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = n[8*b +: 8];
			end
		end
		return r;
	endfunction

	// request taken on the first strobe cycle, answered one cycle later
	assign wbTake = wbCycI & wbStbI & ~ack_q;
	assign wbWrite = wbTake & wbWeI;
	assign selCtrl = (wbAdrI == ADDR_CTRL);
	assign selStat = (wbAdrI == ADDR_STATUS);
	assign selLo = (wbAdrI == ADDR_ALG_LO);
	assign selHi = (wbAdrI == ADDR_ALG_HI);
	assign selSig = (wbAdrI == ADDR_SIG);
	assign ctrlNew = laneMerge(32'(ctrl_q), wbDatI, wbSelI);
	assign loNew = laneMerge(algLo_q, wbDatI, wbSelI);
	assign hiNew = laneMerge(32'(algHi_q), wbDatI, wbSelI);
	assign busStart = wbWrite & selCtrl & wbSelI[0] & wbDatI[CTRL_START];

	// read selection; unmapped addresses read zero
	logic [DW-1:0] sig_q;
	logic [NMEM-1:0] passFlag_q;
	logic failSeen_q;
	mbc_state_type state_q;
	assign statWord = (32'(passFlag_q) << STAT_FLAGS) | (32'(failSeen_q) << STAT_FAIL)
		| (32'(state_q == ST_DONE) << STAT_DONE) | 32'(testBusy);
	always_comb begin
		if (selCtrl) begin
			rdMux = 32'(ctrl_q);
		end else if (selStat) begin
			rdMux = statWord;
		end else if (selLo) begin
			rdMux = algLo_q;
		end else if (selHi) begin
			rdMux = 32'(algHi_q);
		end else if (selSig) begin
			rdMux = 32'(sig_q);
		end else begin
			rdMux = 32'h0000_0000;
		end
	end

	// registers; the start bit is a pulse and is never stored
	always_ff @(posedge clock) begin
		if (reset) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
			ctrl_q <= CTRL_RESET;
			algLo_q <= 32'h0000_0000;
			algHi_q <= '0;
		end else begin
			ack_q <= wbTake;
			if (wbTake) begin
				rdat_q <= rdMux;
			end
			if (wbWrite & selCtrl) begin
				ctrl_q <= ctrlNew[CTRL_W-1:0] & ~CTRL_W'(1 << CTRL_START);
			end
			// program word, also the instruction store in RAM-sourced mode [RL14] [RL16]
			if (wbWrite & selLo) begin
				algLo_q <= loNew;
			end
			if (wbWrite & selHi) begin
				algHi_q <= hiNew[ALG_W-33:0];
			end
		end
	end
	assign wbAckO = ack_q;
	assign wbDatO = rdat_q;

	// ==========================================
	// control decode and clocks
	logic [2:0] potMode;
	logic reducedOn;
	logic romAllowed;
	logic [NMEM-1:0] eligible;
	logic [ALG_W-1:0] algSrc;
	assign potMode = ctrl_q[CTRL_POT +: 3];
	assign reducedOn = ctrl_q[CTRL_REDUCED];
	// ROM memories join only with hardwired or ROM-sourced commands [RL11] [RL12] [RL13]
	assign romAllowed = (potMode == POT_HARDWIRED) | (potMode == POT_ROM);
	assign eligible = romAllowed ? {NMEM{1'b1}} : ~ROM_MASK;
	// default March C+, or the programmed word [RL15] [RL16] [RL14]
	assign algSrc = (ctrl_q[CTRL_PROGRAMMABLE_ALGO_ENABLE] | (potMode == POT_RAM))
		? {algHi_q, algLo_q} : MARCH_CPLUS;
	// test clock from the functional clock only with tracing on [RL3]
	assign testMemClk = (ctrl_q[CTRL_HOOKUP] & ctrl_q[CTRL_TRACE]) ? funcClkIn : clock;
	// ==========================================
	// sequencer
	logic [3:0] elemIdx_q;
	logic [1:0] step_q;
	logic [ADDR_W-1:0] addr_q;
	logic [$clog2(NMEM+1)-1:0] memIdx_q;
	logic par_q;
	mbc_elem_type cur_q;
	mbc_elem_type fetched;
	logic potStart;
	logic startReq;
	logic fetchEnd;
	logic passEnd;
	logic [ADDR_W-1:0] lastAddr;
	logic [ADDR_W-1:0] firstAddr;
	logic [ADDR_W-1:0] endAddr;
	logic [1:0] lastStep;
	logic stepWrite;
	logic stepInv;
	logic [NMEM-1:0] selMask;

	// element fetch, first element in the lowest bits [RL22] [RL13]
	always_comb begin
		if (elemIdx_q >= 4'(ALG_ELEMS)) begin
			fetched = ELEM_EOT;
		end else if (potMode == POT_ROM) begin
			fetched = romElemData;
		end else begin
			fetched = algSrc[ELEM_W*elemIdx_q +: ELEM_W];
		end
	end
	// all-zero entry or an unknown operation ends the pass [RL17]
	assign fetchEnd = (fetched == ELEM_EOT) | ~((fetched.op == OP_READ)
		| (fetched.op == OP_RW) | (fetched.op == OP_RWR) | (fetched.op == OP_WRITE));
	assign passEnd = par_q | (32'(memIdx_q) >= NMEM - 1);
	// pin start in any power-on mode [RL11]
	assign potStart = (potMode != POT_OFF) & pinLvl_q[0] & ~startLvlOld_q;
	assign startReq = (busStart | potStart) & (state_q != ST_ELEM) & (state_q != ST_OP);
	// reduced mode walks four or two corners [RL9] [RL10]
	assign lastAddr = reducedOn ? RED_LAST : {ADDR_W{1'b1}};
	// direction bit: 0 ascending, 1 descending [RL18]
	assign firstAddr = fetched.dir ? lastAddr : '0;
	assign endAddr = cur_q.dir ? '0 : lastAddr;
	// operation decode [RL20]
	assign lastStep = (cur_q.op == OP_RWR) ? 2'd2 : ((cur_q.op == OP_RW) ? 2'd1 : 2'd0);
	assign stepWrite = (cur_q.op == OP_WRITE) | (step_q == 2'd1);
	assign stepInv = (step_q != 2'd0);
	// concurrent run hits every eligible memory at once [RL8]
	assign selMask = par_q ? eligible : (eligible & NMEM'(1 << memIdx_q));

	function automatic logic [ADDR_W-1:0] physAddr(input logic [ADDR_W-1:0] idx,
			input logic red);
		if (!red) begin
			return idx;
		end
		if (COL_W == 0) begin
			return {ADDR_W{idx[0]}}; // [RL10]
		end
		return ({ADDR_W{idx[1]}} & ~COL_MASK) | ({ADDR_W{idx[0]}} & COL_MASK); // [RL9]
	endfunction

	// state machine
	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= ST_IDLE;
			elemIdx_q <= 4'h0;
			step_q <= 2'd0;
			addr_q <= '0;
			memIdx_q <= '0;
			par_q <= 1'b0;
			cur_q <= ELEM_EOT;
		end else begin
			case (state_q)
				ST_IDLE, ST_DONE: begin
					if (startReq) begin
						state_q <= ST_ELEM;
						elemIdx_q <= 4'h0;
						memIdx_q <= '0;
						par_q <= PARALLEL_ON & pinLvl_q[1]; // [RL8]
					end
				end
				ST_ELEM: begin
					if (fetchEnd & passEnd) begin
						state_q <= ST_DONE; // [RL17]
					end else if (fetchEnd) begin
						memIdx_q <= memIdx_q + 1'b1;
						elemIdx_q <= 4'h0;
					end else begin
						cur_q <= fetched;
						addr_q <= firstAddr;
						step_q <= 2'd0;
						state_q <= ST_OP;
					end
				end
				ST_OP: begin
					if (step_q != lastStep) begin
						step_q <= step_q + 2'd1;
					end else if (addr_q == endAddr) begin
						step_q <= 2'd0;
						elemIdx_q <= elemIdx_q + 4'h1; // [RL16]
						state_q <= ST_ELEM;
					end else begin
						step_q <= 2'd0;
						addr_q <= cur_q.dir ? addr_q - 1'b1 : addr_q + 1'b1; // [RL18]
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
	assign testBusy = (state_q == ST_ELEM) | (state_q == ST_OP);
	assign romElemAddr = elemIdx_q; // [RL13]

	// ==========================================
	// memory drive and compare pipeline
	logic [NMEM-1:0] memEn_q;
	logic memWr_q;
	logic [ADDR_W-1:0] memAddr_q;
	logic [DW-1:0] memWd_q;
	logic [NMEM-1:0] rd1_q;
	logic [NMEM-1:0] rd2_q;
	logic [DW-1:0] exp1_q;
	logic [DW-1:0] exp2_q;
	logic [NMEM-1:0] mismatch;
	logic [DW-1:0] romFold;
	logic stepData;
	logic doneEdge;
	logic failPulse_q;

	// data bit: 0 background, 1 inverted background [RL19]
	assign stepData = cur_q.data ^ stepInv;
	always_ff @(posedge clock) begin
		if (reset) begin
			memEn_q <= '0;
			memWr_q <= 1'b0;
			memAddr_q <= '0;
			memWd_q <= '0;
			rd1_q <= '0;
			rd2_q <= '0;
			exp1_q <= '0;
			exp2_q <= '0;
		end else begin
			// ROM memories never see a write
			memEn_q <= (state_q == ST_OP) ? (selMask & (stepWrite ? ~ROM_MASK : '1)) : '0;
			memWr_q <= (state_q == ST_OP) & stepWrite; // [RL20]
			memAddr_q <= physAddr(addr_q, reducedOn);
			memWd_q <= {DW{stepData}}; // [RL19]
			rd1_q <= (state_q == ST_OP & ~stepWrite) ? selMask : '0;
			exp1_q <= {DW{stepData}};
			rd2_q <= rd1_q;
			exp2_q <= exp1_q;
		end
	end
	assign memEnable = memEn_q;
	assign memWrite = memWr_q;
	assign memAddr = memAddr_q;
	assign memWdata = memWd_q;
	// memories stay on the controller clock until the last read has been compared [RL4] [RL21]
	assign memClk = (ctrl_q[CTRL_CLKMUX] & (testBusy | (|memEn_q) | (|rd2_q)))
		? clock : funcClkIn;

	// one comparator per memory; ROM reads fold into a signature
	always_comb begin
		romFold = {sig_q[DW-2:0], sig_q[DW-1]};
		for (int m = 0; m < NMEM; m++) begin
			mismatch[m] = rd2_q[m] & ~ROM_MASK[m] & (memRdata[DW*m +: DW] != exp2_q);
			if (rd2_q[m] & ROM_MASK[m]) begin
				romFold = romFold ^ memRdata[DW*m +: DW];
			end
		end
	end
	assign doneEdge = (state_q == ST_ELEM) & fetchEnd & passEnd;

	// flags: high while passing, cleared on the first failure [RL5] [RL6]
	always_ff @(posedge clock) begin
		if (reset) begin
			passFlag_q <= '1;
			failSeen_q <= 1'b0;
			sig_q <= '0;
			failPulse_q <= 1'b1;
		end else begin
			if (startReq) begin
				passFlag_q <= '1;
				failSeen_q <= 1'b0;
				sig_q <= '0;
			end else begin
				passFlag_q <= passFlag_q & ~mismatch
					& ~((doneEdge & (sig_q != ROM_SIGNATURE)) ? (ROM_MASK & eligible) : '0);
				failSeen_q <= failSeen_q | (|mismatch);
				if (|(rd2_q & ROM_MASK)) begin
					sig_q <= romFold;
				end
			end
			// low for one cycle per failure seen while high, always high again the next cycle [RL7]
			failPulse_q <= ~(ctrl_q[CTRL_DIAGTIME] & (|mismatch) & failPulse_q);
		end
	end
	assign passFlags = passFlag_q | {NMEM{~ctrl_q[CTRL_DIAGMEM]}}; // [RL5]
	assign failPulseFlag = failPulse_q; // [RL7]
	assign potDone = (state_q == ST_DONE); // [RL11]
	assign potPass = (state_q == ST_DONE) & (&passFlag_q);

	// ==========================================
	// shared bypass registers
	logic bypClk;
	logic [NBYP-1:0] byp_q;
	// dedicated bypass clock when built in [RL2]
	assign bypClk = BYPASS_CLK ? bypassClkIn : clock;
	for (genvar g = 0; g < NBYP; g++) begin: gByp
		logic grp;
		// one register per group of shared bits [RL1]
		always_comb begin
			grp = 1'b0;
			for (int j = 0; j < BYP_SHARE; j++) begin
				if (g * BYP_SHARE + j < DW) begin
					grp = grp ^ funcWdata[(g * BYP_SHARE + j) % DW];
				end
			end
		end
		always_ff @(posedge bypClk) begin
			byp_q[g] <= grp; // [RL2]
		end
	end
	for (genvar b = 0; b < DW; b++) begin: gBypOut
		assign bypassData[b] = bypassEn ? byp_q[b / BYP_SHARE] : memRdata[b]; // [RL1]
	end
endmodule

// File: verilog/mbc_pkg.sv
// constants, types and register map of the memory self-test controller
// Notes on behaviour
// [RL1] bypass registers are shared among 1 to 1024 data bits each, cutting their count
// [RL2] optional dedicated bypass clock input clocks the bypass registers
// [RL3] functional hookup drives the test memory clock from the functional clock, needs tracing
// [RL4] clock switch option muxes memory clock onto test clock during test
// [RL5] per-memory pass flag vector, one bit for each memory
// [RL6] pass flag stays high while passing, falls to low on failure
// [RL7] time-of-failure flag drops low for one cycle per detected failure; the code ignores failures detected while it is low
// [RL8] concurrent select pin at 1 starts all memories together
// [RL9] reduced mode tests four addresses: row and column all-zero or all-one
// [RL10] reduced mode without column bits tests only all-zero and all-one rows
// [RL11] basic power-on mode: generic start and result signals, RAM only
// [RL12] hardwired power-on mode: fixed commands, ROM test supported
// [RL13] ROM-sourced power-on mode: commands fetched from a ROM, ROM test supported
// [RL14] RAM-sourced power-on mode: instructions written through a RAM-style interface
// [RL15] default algorithm is March C+ for single-port memories
// [RL16] programmable word lists elements executed in order, rearrangeable
// [RL17] an all-zero element ends the programmed algorithm
// [RL18] direction bit 0 steps addresses up, 1 steps down
// [RL19] data bit 0 uses background, 1 uses inverted background
// [RL20] operation 010 read, 001 read-write, 011 read-write-read, 100 write
// [RL21] test memory clock is the controller clock and clocks memories in test
// [RL22] element packs direction, data, operation; first element in lowest bits
package mbc_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_ALG_LO = 8'h08;
	localparam logic [7:0] ADDR_ALG_HI = 8'h0C;
	localparam logic [7:0] ADDR_SIG = 8'h10;
	// control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_PROGRAMMABLE_ALGO_ENABLE = 1;
	localparam int CTRL_REDUCED = 2;
	localparam int CTRL_POT = 3;
	localparam int CTRL_CLKMUX = 6;
	localparam int CTRL_HOOKUP = 7;
	localparam int CTRL_TRACE = 8;
	localparam int CTRL_DIAGMEM = 9;
	localparam int CTRL_DIAGTIME = 10;
	localparam int CTRL_W = 11;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h600;
	// status register fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_FAIL = 2;
	localparam int STAT_FLAGS = 16;
	// ==========================================
	// algorithm word
	localparam int ALG_ELEMS = 12;
	localparam int ELEM_W = 5;
	localparam int ALG_W = ALG_ELEMS * ELEM_W;
	localparam logic [2:0] OP_READ = 3'h2;
	localparam logic [2:0] OP_RW = 3'h1;
	localparam logic [2:0] OP_RWR = 3'h3;
	localparam logic [2:0] OP_WRITE = 3'h4;
	localparam logic [ELEM_W-1:0] ELEM_EOT = 5'h00;
	// up w0; up r0w1r1; up r1w0r0; down r0w1r1; down r1w0r0; down r0
	localparam logic [ALG_W-1:0] MARCH_CPLUS = {30'h0000_0000,
		5'h12, 5'h1B, 5'h13, 5'h0B, 5'h03, 5'h04};
	// power-on command source
	localparam logic [2:0] POT_OFF = 3'h0;
	localparam logic [2:0] POT_BASIC = 3'h1;
	localparam logic [2:0] POT_HARDWIRED = 3'h2;
	localparam logic [2:0] POT_ROM = 3'h3;
	localparam logic [2:0] POT_RAM = 3'h4;
	// ==========================================
	// types
	typedef struct packed {
		logic dir;
		logic data;
		logic [2:0] op;
	} mbc_elem_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ELEM = 2'b01,
		ST_OP = 2'b10,
		ST_DONE = 2'b11
	} mbc_state_type;
endpackage
